// file: swrs_regs.svh
// Constants of the sleep, wake and reset status sequencer
// Assumes inclusion by the package, the design module and the bench
`ifndef SWRS_REGS_SVH
`define SWRS_REGS_SVH
`define SWRS_ADDR_STATUS   4'h0
`define SWRS_ADDR_PWRCTL   4'h1
`define SWRS_ADDR_CTRL     4'h2
`define SWRS_ADDR_IEN      4'h3
`define SWRS_ADDR_IFLAG    4'h4
`define SWRS_ADDR_STATE    4'h5
`define SWRS_ST_PD_BIT     3
`define SWRS_ST_TO_BIT     4
`define SWRS_PC_STKOVF_BIT 7
`define SWRS_PC_STKUNF_BIT 6
`define SWRS_PC_RMCLR_BIT  3
`define SWRS_PC_RI_BIT     2
`define SWRS_PC_POR_BIT    1
`define SWRS_PC_BOR_BIT    0
`define SWRS_PC_MASK       8'hDF
`define SWRS_ST_POR_VAL    5'h18
`define SWRS_PC_POR_VAL    8'h0C
`define SWRS_PC_BOR_VAL    8'h0E
`define SWRS_VEC_RESET     13'h0000
`define SWRS_VEC_INT       13'h0004
`define SWRS_CLK_RESTART_NS 8
`define SWRS_CLK_PERIOD_NS  4
`define SWRS_NSRC           8
`endif

// file: swrs_pkg.sv
// Types of the sleep, wake and reset status sequencer
// Assumes the constants header sits in the same folder
`include "swrs_regs.svh"
package swrs_pkg;
  typedef enum logic [3:0] {
    SWRS_RUN   = 4'b0001,
    SWRS_SLEEP = 4'b0010,
    SWRS_WAKE  = 4'b0100,
    SWRS_RST   = 4'b1000
  } swrs_state_t;
  typedef logic [12:0] swrs_pc_t;
endpackage

// file: swrs_seq.sv
// Sleep entry, wake-up, reset cause and flag sequencer of a small core
// Assumes core and sources on CLK_SYS; pin resets come asynchronous
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "swrs_regs.svh"
module swrs_seq (
  input  wire logic             CLK_SYS,
  input  wire logic             RSTN,
  input  wire logic             SLEEP_EXEC,
  input  wire swrs_pkg::swrs_pc_t PC_CUR,
  input  wire logic             MASTER_CLEAR_PIN_PIN_N,
  input  wire logic             BOR_EVT,
  input  wire logic             POR_EVT,
  input  wire logic             WDT_TIMEOUT,
  input  wire logic             STK_OVF,
  input  wire logic             STK_UNF,
  input  wire logic             STACK_FAULT_RESET_ENABLE,
  input  wire logic             RESET_INSTR,
  input  wire logic [7:0]       IRQ_COND,
  input  wire logic [7:0]       PIN_OUT,
  input  wire logic [7:0]       PIN_OE,
  input  wire logic [3:0]       ADDR,
  input  wire logic [7:0]       WDATA,
  input  wire logic             WR,
  input  wire logic             RD,
  output logic [7:0]            RDATA,
  output logic                  CPU_CLK_EN,
  output logic                  LOW_FREQ_INTERNAL_OSC_EN,
  output logic                  WDT_CLEAR,
  output logic                  WDT_SLEEP_RUN,
  output logic                  CORE_RESET,
  output logic                  PC_LOAD,
  output swrs_pkg::swrs_pc_t    PC_VALUE,
  output logic                  PUSH_RETURN,
  output logic                  PREFETCH,
  output swrs_pkg::swrs_pc_t    PREFETCH_ADDR,
  output logic                  SLEEPING,
  output logic [7:0]            PIN_OUT_Q,
  output logic [7:0]            PIN_OE_Q
);
  import swrs_pkg::*;

  swrs_state_t state_reg;
  swrs_state_t state_next;
  logic [4:0]  status_reg;
  logic [7:0]  pwrctl_reg;
  logic        gie_reg;
  logic        wdt_sleep_en_reg;
  logic [7:0]  ien_reg;
  logic [7:0]  iflag_reg;
  logic [2:0]  master_clear_pin_sync_reg;
  logic        master_clear_pin_n_reg;
  logic        master_clear_pin_fall;
  logic        wake_cause_int_reg;
  logic [1:0]  restart_cnt_reg;
  logic        int_pend;
  logic        sleep_go;
  logic        nop_sleep;
  logic        wake_int;
  logic        wake_wdt;
  logic        wake_any;
  logic        full_reset;
  logic        stk_rst;

  localparam logic [1:0] RESTART_CYC =
    2'((`SWRS_CLK_RESTART_NS + `SWRS_CLK_PERIOD_NS - 1) / `SWRS_CLK_PERIOD_NS);

  function automatic logic in_state(swrs_state_t s, swrs_state_t t);
    return s == t;
  endfunction

  function automatic logic wr_hit(logic we, logic [3:0] a, logic [3:0] sel);
    return we && a == sel;
  endfunction

  // Pin reset, three stages, change counted when last two agree
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      master_clear_pin_sync_reg <= 3'h7;
      master_clear_pin_n_reg    <= 1'b1;
    end else begin
      master_clear_pin_sync_reg <= {master_clear_pin_sync_reg[1:0], MASTER_CLEAR_PIN_PIN_N};
      if (master_clear_pin_sync_reg[1] == master_clear_pin_sync_reg[2])
        master_clear_pin_n_reg <= master_clear_pin_sync_reg[2];
    end
  end
  assign master_clear_pin_fall = master_clear_pin_n_reg && (master_clear_pin_sync_reg[1] == master_clear_pin_sync_reg[2]) && !master_clear_pin_sync_reg[2];

  assign int_pend   = |(iflag_reg & ien_reg);
  assign sleep_go   = in_state(state_reg, SWRS_RUN) && SLEEP_EXEC && !int_pend;
  assign nop_sleep  = in_state(state_reg, SWRS_RUN) && SLEEP_EXEC && int_pend;
  assign wake_int   = in_state(state_reg, SWRS_SLEEP) && int_pend;
  assign wake_wdt   = in_state(state_reg, SWRS_SLEEP) && WDT_TIMEOUT && !int_pend;
  assign wake_any   = wake_int || wake_wdt;
  assign stk_rst    = STACK_FAULT_RESET_ENABLE && (STK_OVF || STK_UNF);
  assign full_reset = master_clear_pin_fall || BOR_EVT || POR_EVT || stk_rst || RESET_INSTR
                      || (in_state(state_reg, SWRS_RUN) && WDT_TIMEOUT);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SWRS_RUN:   if (sleep_go) state_next = SWRS_SLEEP;
      SWRS_SLEEP: if (wake_int || wake_wdt) state_next = SWRS_WAKE;
      SWRS_WAKE:  if (restart_cnt_reg == 2'h0) state_next = SWRS_RUN;
      SWRS_RST:   state_next = SWRS_RUN;
    endcase
    if (full_reset)
      state_next = SWRS_RST;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN)
      state_reg <= SWRS_RST;
    else
      state_reg <= state_next;
  end

  // Clock held off a few cycles after wake before core fetches
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN)
      restart_cnt_reg <= 2'h0;
    else if (state_next == SWRS_WAKE && !in_state(state_reg, SWRS_WAKE))
      restart_cnt_reg <= RESTART_CYC;
    else if (restart_cnt_reg != 2'h0)
      restart_cnt_reg <= restart_cnt_reg - 2'h1;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN)
      wake_cause_int_reg <= 1'b0;
    else if (wake_int || wake_wdt)
      wake_cause_int_reg <= wake_int;
  end

  // Status flags: timeout, power-down
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      status_reg <= `SWRS_ST_POR_VAL;
    end else if (POR_EVT) begin
      status_reg <= `SWRS_ST_POR_VAL;
    end else if (BOR_EVT) begin
      status_reg[`SWRS_ST_TO_BIT] <= 1'b1;
      status_reg[`SWRS_ST_PD_BIT] <= 1'b1;
    end else if (master_clear_pin_fall && in_state(state_reg, SWRS_SLEEP)) begin
      status_reg[`SWRS_ST_TO_BIT] <= 1'b1;
      status_reg[`SWRS_ST_PD_BIT] <= 1'b0;
    end else if (in_state(state_reg, SWRS_RUN) && WDT_TIMEOUT) begin
      status_reg[`SWRS_ST_TO_BIT] <= 1'b0;
    end else if (sleep_go) begin
      status_reg[`SWRS_ST_TO_BIT] <= 1'b1;
      status_reg[`SWRS_ST_PD_BIT] <= 1'b0;
    end else if (wake_int) begin
      status_reg[`SWRS_ST_TO_BIT] <= 1'b1;
      status_reg[`SWRS_ST_PD_BIT] <= 1'b0;
    end else if (wake_wdt) begin
      status_reg[`SWRS_ST_TO_BIT] <= 1'b0;
      status_reg[`SWRS_ST_PD_BIT] <= 1'b0;
    end else if (wr_hit(WR, ADDR, `SWRS_ADDR_STATUS)) begin
      status_reg[2:0] <= WDATA[2:0];
    end
  end

  // Power control register: reset causes, software writes set them back
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      pwrctl_reg <= `SWRS_PC_POR_VAL;
    end else if (POR_EVT) begin
      pwrctl_reg <= `SWRS_PC_POR_VAL;
    end else if (BOR_EVT) begin
      pwrctl_reg <= `SWRS_PC_BOR_VAL;
      // Power-on flag left as it was
      pwrctl_reg[`SWRS_PC_POR_BIT] <= pwrctl_reg[`SWRS_PC_POR_BIT];
    end else begin
      if (wr_hit(WR, ADDR, `SWRS_ADDR_PWRCTL))
        pwrctl_reg <= WDATA & `SWRS_PC_MASK;
      if (master_clear_pin_fall)
        pwrctl_reg[`SWRS_PC_RMCLR_BIT] <= 1'b0;
      if (RESET_INSTR)
        pwrctl_reg[`SWRS_PC_RI_BIT] <= 1'b0;
      if (STACK_FAULT_RESET_ENABLE && STK_OVF)
        pwrctl_reg[`SWRS_PC_STKOVF_BIT] <= 1'b1;
      if (STACK_FAULT_RESET_ENABLE && STK_UNF)
        pwrctl_reg[`SWRS_PC_STKUNF_BIT] <= 1'b1;
    end
  end

  // Software control and enables
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      gie_reg          <= 1'b0;
      wdt_sleep_en_reg <= 1'b0;
      ien_reg          <= 8'h00;
    end else begin
      if (wr_hit(WR, ADDR, `SWRS_ADDR_CTRL)) begin
        gie_reg          <= WDATA[0];
        wdt_sleep_en_reg <= WDATA[1];
      end
      if (wr_hit(WR, ADDR, `SWRS_ADDR_IEN))
        ien_reg <= WDATA;
    end
  end

  // Interrupt flags; a new condition wins over a software clear
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN)
      iflag_reg <= 8'h00;
    else if (wr_hit(WR, ADDR, `SWRS_ADDR_IFLAG))
      iflag_reg <= WDATA | IRQ_COND;
    else
      iflag_reg <= iflag_reg | IRQ_COND;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= 8'h00;
      if (RD) begin
        unique case (ADDR)
          `SWRS_ADDR_STATUS: RDATA <= {3'h0, status_reg};
          `SWRS_ADDR_PWRCTL: RDATA <= pwrctl_reg;
          `SWRS_ADDR_CTRL:   RDATA <= {6'h00, wdt_sleep_en_reg, gie_reg};
          `SWRS_ADDR_IEN:    RDATA <= ien_reg;
          `SWRS_ADDR_IFLAG:  RDATA <= iflag_reg;
          `SWRS_ADDR_STATE:  RDATA <= {4'h0, state_reg};
          default:           RDATA <= 8'h00;
        endcase
      end
    end
  end

  // Clock, watchdog and core control
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      CPU_CLK_EN               <= 1'b0;
      LOW_FREQ_INTERNAL_OSC_EN <= 1'b1;
      WDT_CLEAR                <= 1'b0;
      WDT_SLEEP_RUN            <= 1'b0;
      CORE_RESET               <= 1'b1;
      SLEEPING                 <= 1'b0;
    end else begin
      CPU_CLK_EN    <= in_state(state_next, SWRS_RUN);
      LOW_FREQ_INTERNAL_OSC_EN <= 1'b1;
      WDT_CLEAR     <= sleep_go || wake_any;
      WDT_SLEEP_RUN <= in_state(state_next, SWRS_SLEEP) && wdt_sleep_en_reg;
      CORE_RESET    <= full_reset;
      SLEEPING      <= in_state(state_next, SWRS_SLEEP);
    end
  end

  // Program counter and prefetch control
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      PC_LOAD       <= 1'b0;
      PC_VALUE      <= `SWRS_VEC_RESET;
      PUSH_RETURN   <= 1'b0;
      PREFETCH      <= 1'b0;
      PREFETCH_ADDR <= `SWRS_VEC_RESET;
    end else begin
      PC_LOAD     <= 1'b0;
      PUSH_RETURN <= 1'b0;
      PREFETCH    <= SLEEP_EXEC && in_state(state_reg, SWRS_RUN);
      if (SLEEP_EXEC)
        PREFETCH_ADDR <= PC_CUR + 13'h0001;
      if (full_reset) begin
        PC_LOAD  <= 1'b1;
        PC_VALUE <= `SWRS_VEC_RESET;
      end else if (in_state(state_reg, SWRS_WAKE) && restart_cnt_reg == 2'h0
                   && wake_cause_int_reg && gie_reg) begin
        PUSH_RETURN <= 1'b1;
        PC_LOAD     <= 1'b1;
        PC_VALUE    <= `SWRS_VEC_INT;
      end
    end
  end

  // Pin drive frozen while asleep
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      PIN_OUT_Q <= 8'h00;
      PIN_OE_Q  <= 8'h00;
    end else if (!in_state(state_next, SWRS_SLEEP) && !in_state(state_reg, SWRS_SLEEP)) begin
      PIN_OUT_Q <= PIN_OUT;
      PIN_OE_Q  <= PIN_OE;
    end
  end

  AST_SLEEP_ONLY_ON_INSTR: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    $rose(SLEEPING) |-> $past(SLEEP_EXEC, 1)) else $error("sleep without instruction");
  AST_NOP_SLEEP: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    nop_sleep && !full_reset |=> !SLEEPING && $stable(status_reg)) else $error("sleep not no-op");
  AST_ENTRY_FLAGS: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    sleep_go && !full_reset |=> status_reg[`SWRS_ST_TO_BIT] && !status_reg[`SWRS_ST_PD_BIT])
    else $error("entry flags wrong");
  AST_CLK_OFF: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    SLEEPING |-> !CPU_CLK_EN) else $error("clock runs in sleep");
  AST_WAKE_WDT_CLR: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (wake_int || wake_wdt) |=> WDT_CLEAR) else $error("no watchdog clear");
  AST_INT_WAKE_SOON: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    wake_int && !full_reset |-> ##[1:4] CPU_CLK_EN) else $error("interrupt wake late");
  AST_PINS_HELD: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    SLEEPING && $past(SLEEPING) |-> $stable(PIN_OE_Q) && $stable(PIN_OUT_Q)) else $error("pins moved");
  AST_VECTOR: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    PUSH_RETURN |-> PC_LOAD && PC_VALUE == `SWRS_VEC_INT) else $error("bad vector");
  AST_RESET_PC: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    full_reset |=> CORE_RESET && PC_VALUE == `SWRS_VEC_RESET) else $error("reset pc wrong");
  AST_FLAG_SET: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    |IRQ_COND |=> (iflag_reg & $past(IRQ_COND)) == $past(IRQ_COND)) else $error("flag lost");
  AST_PREFETCH_ADDR: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    SLEEP_EXEC && in_state(state_reg, SWRS_RUN) |=> PREFETCH && PREFETCH_ADDR == $past(PC_CUR) + 13'h0001)
    else $error("prefetch address wrong");
  AST_WDT_WAKE_FLAGS: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    wake_wdt && !full_reset |=> !status_reg[`SWRS_ST_TO_BIT] && !status_reg[`SWRS_ST_PD_BIT])
    else $error("watchdog wake flags wrong");
  AST_NOP_NO_CLEAR: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    nop_sleep |=> !WDT_CLEAR)
    else $error("no-op sleep cleared watchdog");
  AST_PIN_FLAG_CLR: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    master_clear_pin_fall && !POR_EVT && !BOR_EVT |=> !pwrctl_reg[`SWRS_PC_RMCLR_BIT])
    else $error("pin flag kept");
  AST_UNIMPL_ZERO: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    RD && ADDR == `SWRS_ADDR_STATUS |=> RDATA[7:5] == 3'h0)
    else $error("unimplemented bits set");
  COV_SLEEP: cover property (@(posedge CLK_SYS) disable iff (!RSTN) sleep_go);
  COV_INT_WAKE: cover property (@(posedge CLK_SYS) disable iff (!RSTN) wake_int);
  COV_WDT_WAKE: cover property (@(posedge CLK_SYS) disable iff (!RSTN) wake_wdt);
  COV_NOP: cover property (@(posedge CLK_SYS) disable iff (!RSTN) nop_sleep);
  COV_PIN_SLEEP: cover property (@(posedge CLK_SYS) disable iff (!RSTN) master_clear_pin_fall && in_state(state_reg, SWRS_SLEEP));
endmodule

// file: swrs_core_model.sv
// Model of the core and event sources around the sleep, wake and reset sequencer
// Assumes the bench calls its tasks from one process, all on CLK_SYS
`timescale 1ns/1ps
module swrs_core_model (
  input  wire logic          CLK_SYS,
  output logic               SLEEP_EXEC,
  output swrs_pkg::swrs_pc_t PC_CUR,
  output logic               MASTER_CLEAR_PIN_PIN_N,
  output logic               WDT_TIMEOUT,
  output logic               STK_OVF,
  output logic               STK_UNF,
  output logic               RESET_INSTR,
  output logic               BOR_EVT,
  output logic               POR_EVT,
  output logic [7:0]         IRQ_COND,
  output logic [7:0]         PIN_OUT,
  output logic [7:0]         PIN_OE
);
  import swrs_pkg::*;
  initial begin
    {RESET_INSTR, STK_UNF, STK_OVF, WDT_TIMEOUT, SLEEP_EXEC} = 5'h00;
    PC_CUR     = 13'h0000;
    MASTER_CLEAR_PIN_PIN_N = 1'b1;
    BOR_EVT    = 1'b0;
    POR_EVT    = 1'b0;
    IRQ_COND   = 8'h00;
    PIN_OUT    = 8'h00;
    PIN_OE     = 8'h00;
  end
  // One-cycle event; the word after each sleep is a no-op
  task automatic pulse(input logic [4:0] k, input logic [7:0] m, input swrs_pc_t pc);
    @(posedge CLK_SYS);
    {RESET_INSTR, STK_UNF, STK_OVF, WDT_TIMEOUT, SLEEP_EXEC} <= k;
    IRQ_COND <= m;
    PC_CUR   <= pc;
    @(posedge CLK_SYS);
    {RESET_INSTR, STK_UNF, STK_OVF, WDT_TIMEOUT, SLEEP_EXEC} <= 5'h00;
    IRQ_COND <= 8'h00;
  endtask
  task automatic pins(input logic [7:0] o, input logic [7:0] e);
    @(posedge CLK_SYS);
    PIN_OUT <= o;
    PIN_OE  <= e;
  endtask
  // Supply supervisor events, one cycle each
  task automatic supply(input logic b, input logic p);
    @(posedge CLK_SYS);
    BOR_EVT <= b;
    POR_EVT <= p;
    @(posedge CLK_SYS);
    BOR_EVT <= 1'b0;
    POR_EVT <= 1'b0;
  endtask
  // Pin has a pull-up, so release returns it high
  task automatic pin_reset();
    @(posedge CLK_SYS);
    MASTER_CLEAR_PIN_PIN_N <= 1'b0;
    repeat (8) @(posedge CLK_SYS);
    MASTER_CLEAR_PIN_PIN_N <= 1'b1;
  endtask
endmodule

// file: swrs_seq_tb.sv
// Self-checking bench of the sleep, wake and reset sequencer
// Assumes the core model file and the design package are compiled first
`timescale 1ns/1ps
`include "swrs_regs.svh"
module swrs_seq_tb;
  import swrs_pkg::*;
  logic clk, rstn, sx, master_clear_pin_n, wdt, ovf, unf, ri, wr, rd, mon, bor, por, sfre;
  logic [7:0] irq, po, pe, wdata, rdata, poq, peq;
  logic [3:0] addr;
  logic clk_en, osc_en, wclr, wrun, crst, pload, push, pf, slp;
  swrs_pc_t pc_cur, pc_val, pf_addr, pc_seen;
  int fail_count, checked, n_load, n_push, n_wclr, n_rst;
  swrs_seq u_dut (.CLK_SYS(clk), .RSTN(rstn), .SLEEP_EXEC(sx), .PC_CUR(pc_cur), .MASTER_CLEAR_PIN_PIN_N(master_clear_pin_n),
    .BOR_EVT(bor), .POR_EVT(por), .WDT_TIMEOUT(wdt), .STK_OVF(ovf), .STK_UNF(unf),
    .STACK_FAULT_RESET_ENABLE(sfre), .RESET_INSTR(ri), .IRQ_COND(irq), .PIN_OUT(po), .PIN_OE(pe),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .CPU_CLK_EN(clk_en),
    .LOW_FREQ_INTERNAL_OSC_EN(osc_en), .WDT_CLEAR(wclr), .WDT_SLEEP_RUN(wrun), .CORE_RESET(crst),
    .PC_LOAD(pload), .PC_VALUE(pc_val), .PUSH_RETURN(push), .PREFETCH(pf), .PREFETCH_ADDR(pf_addr),
    .SLEEPING(slp), .PIN_OUT_Q(poq), .PIN_OE_Q(peq));
  swrs_core_model u_core (.CLK_SYS(clk), .SLEEP_EXEC(sx), .PC_CUR(pc_cur), .MASTER_CLEAR_PIN_PIN_N(master_clear_pin_n),
    .WDT_TIMEOUT(wdt), .STK_OVF(ovf), .STK_UNF(unf), .RESET_INSTR(ri), .IRQ_COND(irq),
    .BOR_EVT(bor), .POR_EVT(por),
    .PIN_OUT(po), .PIN_OE(pe));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Event tallies, counted only once reset is over
  always @(posedge clk) begin
    if (mon === 1'b1) begin
      if (pload === 1'b1) begin
        n_load  <= n_load + 1;
        pc_seen <= pc_val;
      end
      if (push === 1'b1) n_push <= n_push + 1;
      if (wclr === 1'b1) n_wclr <= n_wclr + 1;
      if (crst === 1'b1) n_rst <= n_rst + 1;
    end
  end
  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(nm, {5'h00, e}, {5'h00, rdata});
  endtask
  task automatic wait_run();
    int i;
    for (i = 0; i < 20 && clk_en !== 1'b1; i++) @(posedge clk);
    repeat (3) @(posedge clk);
    #1;
  endtask
  initial begin
    #20000;
    fail_count++;
    end_sim();
  end
  initial begin
    {rstn, wr, rd, mon} = 4'h0;
    sfre    = 1'b1;
    addr    = 4'h0;
    wdata   = 8'h00;
    pc_seen = 13'h1FFF;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    wait_run();
    mon = 1'b1;
    rreg(`SWRS_ADDR_STATUS, 8'h18, "status");
    rreg(`SWRS_ADDR_PWRCTL, 8'h0C, "pwrctl");
    rreg(4'hF, 8'h00, "unmapped");
    chk("osc", 13'h1, osc_en);
    wreg(`SWRS_ADDR_CTRL, 8'h03);
    wreg(`SWRS_ADDR_IEN, 8'h01);
    u_core.pins(8'hA5, 8'h0F);
    u_core.pulse(5'h01, 8'h00, 13'h0100);
    #1;
    chk("sleeping", 13'h1, slp);
    chk("clk_en", 13'h0, clk_en);
    chk("wclr", 13'h1, wclr);
    chk("wrun", 13'h1, wrun);
    chk("prefetch", 13'h1, pf);
    chk("pf_addr", 13'h0101, pf_addr);
    chk("osc", 13'h1, osc_en);
    u_core.pins(8'h5A, 8'hF0);
    rreg(`SWRS_ADDR_STATUS, 8'h10, "status");
    chk("pin_out", 13'h0A5, poq);
    chk("pin_oe", 13'h00F, peq);
    u_core.pulse(5'h00, 8'h04, 13'h0100);
    repeat (6) @(posedge clk);
    #1;
    chk("sleeping", 13'h1, slp);
    rreg(`SWRS_ADDR_IFLAG, 8'h04, "iflag");
    u_core.pulse(5'h00, 8'h01, 13'h0100);
    wait_run();
    chk("sleeping", 13'h0, slp);
    chk("clk_en", 13'h1, clk_en);
    chk("n_load", 13'h1, n_load);
    chk("vector", `SWRS_VEC_INT, pc_seen);
    chk("n_push", 13'h1, n_push);
    chk("n_wclr", 13'h2, n_wclr);
    rreg(`SWRS_ADDR_STATUS, 8'h10, "status");
    wreg(`SWRS_ADDR_IFLAG, 8'h00);
    wreg(`SWRS_ADDR_CTRL, 8'h02);
    u_core.pulse(5'h01, 8'h00, 13'h0200);
    u_core.pulse(5'h02, 8'h00, 13'h0200);
    wait_run();
    chk("n_load", 13'h1, n_load);
    chk("n_wclr", 13'h4, n_wclr);
    rreg(`SWRS_ADDR_STATUS, 8'h00, "status");
    u_core.pulse(5'h00, 8'h01, 13'h0300);
    u_core.pulse(5'h01, 8'h00, 13'h0300);
    #1;
    chk("sleeping", 13'h0, slp);
    chk("wclr", 13'h0, wclr);
    chk("prefetch", 13'h1, pf);
    rreg(`SWRS_ADDR_STATUS, 8'h00, "status");
    wreg(`SWRS_ADDR_IFLAG, 8'h00);
    u_core.pulse(5'h01, 8'h00, 13'h0380);
    u_core.pulse(5'h00, 8'h01, 13'h0380);
    wait_run();
    chk("n_load", 13'h1, n_load);
    chk("n_push", 13'h1, n_push);
    chk("n_wclr", 13'h6, n_wclr);
    rreg(`SWRS_ADDR_STATUS, 8'h10, "status");
    wreg(`SWRS_ADDR_IFLAG, 8'h00);
    u_core.pulse(5'h01, 8'h00, 13'h0400);
    u_core.pin_reset();
    wait_run();
    chk("n_rst", 13'h1, n_rst);
    chk("n_load", 13'h2, n_load);
    chk("reset pc", `SWRS_VEC_RESET, pc_seen);
    rreg(`SWRS_ADDR_STATUS, 8'h10, "status");
    rreg(`SWRS_ADDR_PWRCTL, 8'h04, "pwrctl");
    wreg(`SWRS_ADDR_PWRCTL, 8'h0C);
    wreg(`SWRS_ADDR_STATUS, 8'h02);
    u_core.pin_reset();
    wait_run();
    chk("n_load", 13'h3, n_load);
    chk("reset pc", `SWRS_VEC_RESET, pc_seen);
    rreg(`SWRS_ADDR_STATUS, 8'h12, "status");
    rreg(`SWRS_ADDR_PWRCTL, 8'h04, "pwrctl");
    u_core.pulse(5'h04, 8'h00, 13'h0000);
    wait_run();
    rreg(`SWRS_ADDR_PWRCTL, 8'h84, "pwrctl");
    chk("reset pc", `SWRS_VEC_RESET, pc_seen);
    chk("n_load", 13'h4, n_load);
    u_core.pulse(5'h08, 8'h00, 13'h0000);
    wait_run();
    rreg(`SWRS_ADDR_PWRCTL, 8'hC4, "pwrctl");
    u_core.pulse(5'h10, 8'h00, 13'h0000);
    wait_run();
    rreg(`SWRS_ADDR_PWRCTL, 8'hC0, "pwrctl");
    chk("n_rst", 13'h5, n_rst);
    wreg(`SWRS_ADDR_PWRCTL, 8'h00);
    @(posedge clk);
    sfre <= 1'b0;
    u_core.pulse(5'h04, 8'h00, 13'h0000);
    rreg(`SWRS_ADDR_PWRCTL, 8'h00, "pwrctl");
    chk("n_rst", 13'h5, n_rst);
    @(posedge clk);
    sfre <= 1'b1;
    wreg(`SWRS_ADDR_STATUS, 8'h05);
    u_core.supply(1'b1, 1'b0);
    wait_run();
    rreg(`SWRS_ADDR_STATUS, 8'h1D, "status");
    rreg(`SWRS_ADDR_PWRCTL, 8'h0C, "pwrctl");
    wreg(`SWRS_ADDR_PWRCTL, 8'hE3);
    rreg(`SWRS_ADDR_PWRCTL, 8'hC3, "pwrctl");
    u_core.supply(1'b0, 1'b1);
    wait_run();
    rreg(`SWRS_ADDR_STATUS, 8'h18, "status");
    rreg(`SWRS_ADDR_PWRCTL, 8'h0C, "pwrctl");
    chk("n_rst", 13'h7, n_rst);
    rreg(`SWRS_ADDR_CTRL, 8'h02, "ctrl");
    rreg(`SWRS_ADDR_STATE, 8'h01, "state");
    end_sim();
  end
endmodule
